// ==== hw/uib_pkg.sv ====
package uib_pkg;
  localparam int ADDR_W = 6;
  localparam int DATA_W = 32;
  localparam int REG_IDX_W = 4;
  localparam logic [3:0] IDX_RXDATA_LOW = 4'h0;
  localparam logic [3:0] IDX_RXDATA_HIGH = 4'h1;
  localparam logic [3:0] IDX_TXDATA_LOW = 4'h2;
  localparam logic [3:0] IDX_TXDATA_HIGH = 4'h3;
  localparam logic [3:0] IDX_STATUS = 4'h4;
  localparam logic [3:0] IDX_CTRL_IRQ = 4'h5;
  localparam logic [3:0] IDX_CTRL_ENABLE = 4'h6;
  localparam logic [3:0] IDX_CTRL_FRAME = 4'h7;
  localparam logic [3:0] IDX_BAUD = 4'h8;
  localparam logic [3:0] IDX_DEBUG = 4'hB;
  localparam logic [3:0] IDX_EVENT = 4'hC;
  localparam logic [3:0] IDX_TX_PULSE = 4'hD;
  localparam logic [3:0] IDX_RX_PULSE = 4'hE;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [15:0] RESET_BAUD = 16'h0000;
  localparam int RXH_UNREAD = 7;
  localparam int RXH_OVERFLOW = 6;
  localparam int RXH_FRAME_ERR = 2;
  localparam int RXH_PARITY_ERR = 1;
  localparam int RXH_DATA9 = 0;
  localparam int ST_RX_UNREAD = 7;
  localparam int ST_TX_DONE = 6;
  localparam int ST_TX_EMPTY = 5;
  localparam int ST_RX_START = 4;
  localparam int ST_BAD_SYNC = 3;
  localparam int ST_BREAK = 1;
  localparam int ST_WAIT_BREAK = 0;
  localparam int CA_RX_IE = 7;
  localparam int CA_TXC_IE = 6;
  localparam int CA_DRE_IE = 5;
  localparam int CA_RXS_IE = 4;
  localparam int CA_ABE_IE = 2;
  localparam int CB_RX_EN = 7;
  localparam int CB_START_DET_EN = 4;
  localparam int EV_IR_ENABLE = 0;
  localparam int CC_MODE_HI = 7;
  localparam int CC_MODE_LO = 6;
  localparam int CC_PAR_HI = 5;
  localparam int CC_PAR_LO = 4;
  localparam int CC_SIZE_HI = 2;
  localparam int CC_SIZE_LO = 0;
  localparam logic [1:0] MODE_SPI_MASTER = 2'h3;
  localparam logic [1:0] PARITY_OFF = 2'h0;
  localparam logic [2:0] SIZE_NINE_LOW_FIRST = 3'h6;
  localparam logic [6:0] RX_PULSE_MASK = 7'h7F;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef logic [11:0] uib_entry_t;
endpackage : uib_pkg

// ==== hw/uib_uart_regs.sv ====
// Our own choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module uib_uart_regs
  import uib_pkg::*;
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic rx_pin,
  input wire logic ir_event_in,
  input wire logic rx_char_valid,
  input wire logic [8:0] rx_char_data,
  input wire logic rx_first_stop_bit,
  input wire logic rx_parity_bad,
  input wire logic rx_start_seen,
  input wire logic sync_error_seen,
  input wire logic break_seen,
  input wire logic tx_buffer_taken,
  input wire logic tx_frame_sent,
  output logic ir_rx_source_r,
  output logic [7:0] tx_data_r,
  output logic tx_data9_r,
  output logic tx_buffer_full_r,
  output logic wait_break_r,
  output logic [7:0] interrupt_enable_control_r,
  output logic [7:0] enable_and_rx_mode_control_r,
  output logic [7:0] frame_format_control_r,
  output logic [15:0] bit_rate_divisor_r,
  output logic [7:0] debug_run_control_r,
  output logic [7:0] ir_tx_pulse_length_r,
  output logic [6:0] ir_rx_pulse_length_r,
  output logic receive_complete_vector_r,
  output logic tx_buffer_empty_vector_r,
  output logic transmit_complete_vector_r
);

  logic [3:0] aw_idx_r;
  logic aw_have_r;
  logic [DATA_W-1:0] wdata_r;
  logic [3:0] wstrb_r;
  logic w_have_r;
  logic wr_go;
  logic rd_go;
  logic [3:0] ar_idx;
  logic [7:0] event_input_control_r;
  logic tx_done_flag_r;
  logic rx_start_flag_r;
  logic bad_sync_field_flag_r;
  logic break_flag_r;
  uib_entry_t fifo_r [0:1];
  logic rd_ptr_r;
  logic [1:0] count_r;
  uib_entry_t held_r;
  logic held_v_r;
  uib_entry_t head;
  uib_entry_t incoming;
  logic rx_unread_flag;
  logic tx_buffer_empty_flag;
  logic rx_enabled;
  logic spi_master;
  logic parity_on;
  logic nine_low_first;
  logic pop;
  logic push;
  logic [7:0] status_byte;
  logic [7:0] rx_high_byte;
  logic [7:0] rd_byte;
  logic [15:0] rd_word;
  logic rd_mapped;
  logic wr_mapped;

  assign wr_go = aw_have_r && w_have_r && !s_axi_bvalid;
  assign rd_go = s_axi_arvalid && s_axi_arready;
  assign ar_idx = s_axi_araddr[5:2];
  assign rx_enabled = enable_and_rx_mode_control_r[CB_RX_EN];
  assign spi_master = frame_format_control_r[CC_MODE_HI:CC_MODE_LO] == MODE_SPI_MASTER;
  assign parity_on = frame_format_control_r[CC_PAR_HI:CC_PAR_LO] != PARITY_OFF;
  assign nine_low_first =
    frame_format_control_r[CC_SIZE_HI:CC_SIZE_LO] == SIZE_NINE_LOW_FIRST;
  assign head = fifo_r[rd_ptr_r];
  assign rx_unread_flag = count_r != 2'h0;
  assign tx_buffer_empty_flag = !tx_buffer_full_r;

  // The buffer advances on the low byte read, or the high byte read in low-first mode.
  always_comb begin
    pop = 1'b0;
    if (rd_go && rx_unread_flag) begin
      if (nine_low_first) begin
        pop = ar_idx == IDX_RXDATA_HIGH;
      end else begin
        pop = ar_idx == IDX_RXDATA_LOW;
      end
    end
  end

  assign push = held_v_r && (count_r != 2'h2 || pop);

  // A finished character is tagged with its own frame and parity status.
  always_comb begin
    incoming = '0;
    incoming[8:0] = rx_char_data;
    incoming[9] = !rx_first_stop_bit && !spi_master;
    incoming[10] = rx_parity_bad && parity_on;
  end

  // Write address and data are caught in either order.
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      aw_have_r <= 1'b0;
      aw_idx_r <= 4'h0;
      s_axi_awready <= 1'b1;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_have_r <= 1'b1;
      aw_idx_r <= s_axi_awaddr[5:2];
      s_axi_awready <= 1'b0;
    end else if (s_axi_bvalid && s_axi_bready) begin
      aw_have_r <= 1'b0;
      s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      w_have_r <= 1'b0;
      wdata_r <= '0;
      wstrb_r <= 4'h0;
      s_axi_wready <= 1'b1;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_have_r <= 1'b1;
      wdata_r <= s_axi_wdata;
      wstrb_r <= s_axi_wstrb;
      s_axi_wready <= 1'b0;
    end else if (s_axi_bvalid && s_axi_bready) begin
      w_have_r <= 1'b0;
      s_axi_wready <= 1'b1;
    end
  end

  always_comb begin
    unique case (aw_idx_r)
      IDX_RXDATA_LOW, IDX_RXDATA_HIGH, IDX_TXDATA_LOW, IDX_TXDATA_HIGH, IDX_STATUS,
      IDX_CTRL_IRQ, IDX_CTRL_ENABLE, IDX_CTRL_FRAME, IDX_BAUD, IDX_DEBUG, IDX_EVENT,
      IDX_TX_PULSE, IDX_RX_PULSE: wr_mapped = 1'b1;
      default: wr_mapped = 1'b0;
    endcase
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Plain control registers written through byte lane 0, baud high byte through lane 1.
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      interrupt_enable_control_r <= RESET_BYTE;
      enable_and_rx_mode_control_r <= RESET_BYTE;
      frame_format_control_r <= RESET_BYTE;
      bit_rate_divisor_r <= RESET_BAUD;
      debug_run_control_r <= RESET_BYTE;
      event_input_control_r <= RESET_BYTE;
      ir_tx_pulse_length_r <= RESET_BYTE;
      ir_rx_pulse_length_r <= RESET_BYTE[6:0];
    end else if (wr_go) begin
      if (wstrb_r[0]) begin
        unique case (aw_idx_r)
          IDX_CTRL_IRQ: interrupt_enable_control_r <= wdata_r[7:0];
          IDX_CTRL_ENABLE: enable_and_rx_mode_control_r <= wdata_r[7:0];
          IDX_CTRL_FRAME: frame_format_control_r <= wdata_r[7:0];
          IDX_BAUD: bit_rate_divisor_r[7:0] <= wdata_r[7:0];
          IDX_DEBUG: debug_run_control_r <= wdata_r[7:0];
          IDX_EVENT: event_input_control_r <= wdata_r[7:0];
          IDX_TX_PULSE: ir_tx_pulse_length_r <= wdata_r[7:0];
          IDX_RX_PULSE: ir_rx_pulse_length_r <= wdata_r[6:0] & RX_PULSE_MASK;
          default: ;
        endcase
      end
      if (wstrb_r[1] && aw_idx_r == IDX_BAUD) begin
        bit_rate_divisor_r[15:8] <= wdata_r[15:8];
      end
    end
  end

  // The IR receiver takes the event input only while it is enabled.
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ir_rx_source_r <= 1'b1;
    end else begin
      ir_rx_source_r <= event_input_control_r[EV_IR_ENABLE] ? ir_event_in : rx_pin;
    end
  end

  // Transmit buffer accepts a character only while it is empty.
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      tx_buffer_full_r <= 1'b0;
      tx_data_r <= RESET_BYTE;
      tx_data9_r <= 1'b0;
    end else begin
      if (wr_go && wstrb_r[0] && aw_idx_r == IDX_TXDATA_LOW && tx_buffer_empty_flag) begin
        tx_buffer_full_r <= 1'b1;
        tx_data_r <= wdata_r[7:0];
      end else if (tx_buffer_taken) begin
        tx_buffer_full_r <= 1'b0;
      end
      if (wr_go && wstrb_r[0] && aw_idx_r == IDX_TXDATA_HIGH) begin
        tx_data9_r <= wdata_r[0];
      end
    end
  end

  // Sticky status flags set whatever the interrupt enables, start flag only with start detection on; a one written clears, a set wins.
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      tx_done_flag_r <= 1'b0;
      rx_start_flag_r <= 1'b0;
      bad_sync_field_flag_r <= 1'b0;
      break_flag_r <= 1'b0;
      wait_break_r <= 1'b0;
    end else begin
      wait_break_r <= 1'b0;
      if (wr_go && wstrb_r[0] && aw_idx_r == IDX_STATUS) begin
        if (wdata_r[ST_TX_DONE]) tx_done_flag_r <= 1'b0;
        if (wdata_r[ST_RX_START]) rx_start_flag_r <= 1'b0;
        if (wdata_r[ST_BAD_SYNC]) bad_sync_field_flag_r <= 1'b0;
        if (wdata_r[ST_BREAK]) break_flag_r <= 1'b0;
        wait_break_r <= wdata_r[ST_WAIT_BREAK];
      end
      if (tx_frame_sent && !tx_buffer_full_r) begin
        tx_done_flag_r <= 1'b1;
      end
      if (rx_start_seen && enable_and_rx_mode_control_r[CB_START_DET_EN]) begin
        rx_start_flag_r <= 1'b1;
      end
      if (sync_error_seen) begin
        bad_sync_field_flag_r <= 1'b1;
      end
      if (break_seen) begin
        break_flag_r <= 1'b1;
      end
    end
  end

  // Two-entry receive buffer fed from a one-character waiting slot.
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      fifo_r[0] <= '0;
      fifo_r[1] <= '0;
      rd_ptr_r <= 1'b0;
      count_r <= 2'h0;
      held_r <= '0;
      held_v_r <= 1'b0;
    end else if (!rx_enabled) begin
      rd_ptr_r <= 1'b0;
      count_r <= 2'h0;
      held_v_r <= 1'b0;
    end else begin
      if (push) begin
        fifo_r[rd_ptr_r ^ count_r[0] ^ (pop ? 1'b1 : 1'b0) ^ (pop ? 1'b1 : 1'b0)] <= held_r;
      end
      if (pop) begin
        rd_ptr_r <= !rd_ptr_r;
      end
      unique case ({push, pop})
        2'b10: count_r <= count_r + 2'h1;
        2'b01: count_r <= count_r - 2'h1;
        default: ;
      endcase
      if (rx_char_valid && (!held_v_r || push)) begin
        held_r <= incoming;
        held_v_r <= 1'b1;
      end else begin
        if (push) begin
          held_v_r <= 1'b0;
        end
        if (rx_start_seen && held_v_r && count_r == 2'h2 && !pop && !spi_master) begin
          held_r[11] <= 1'b1;
        end
      end
    end
  end

  always_comb begin
    status_byte = '0;
    status_byte[ST_RX_UNREAD] = rx_unread_flag;
    status_byte[ST_TX_DONE] = tx_done_flag_r;
    status_byte[ST_TX_EMPTY] = tx_buffer_empty_flag;
    status_byte[ST_RX_START] = rx_start_flag_r;
    status_byte[ST_BAD_SYNC] = bad_sync_field_flag_r;
    status_byte[ST_BREAK] = break_flag_r;
    rx_high_byte = '0;
    if (rx_unread_flag) begin
      rx_high_byte[RXH_UNREAD] = 1'b1;
      rx_high_byte[RXH_OVERFLOW] = head[11];
      rx_high_byte[RXH_FRAME_ERR] = head[9];
      rx_high_byte[RXH_PARITY_ERR] = head[10];
      rx_high_byte[RXH_DATA9] = head[8];
    end
  end

  always_comb begin
    rd_byte = '0;
    rd_word = '0;
    rd_mapped = 1'b1;
    unique case (ar_idx)
      IDX_RXDATA_LOW: rd_byte = rx_unread_flag ? head[7:0] : RESET_BYTE;
      IDX_RXDATA_HIGH: rd_byte = rx_high_byte;
      IDX_TXDATA_LOW: rd_byte = tx_data_r;
      IDX_TXDATA_HIGH: rd_byte = RESET_BYTE;
      IDX_STATUS: rd_byte = status_byte;
      IDX_CTRL_IRQ: rd_byte = interrupt_enable_control_r;
      IDX_CTRL_ENABLE: rd_byte = enable_and_rx_mode_control_r;
      IDX_CTRL_FRAME: rd_byte = frame_format_control_r;
      IDX_BAUD: rd_word = bit_rate_divisor_r;
      IDX_DEBUG: rd_byte = debug_run_control_r;
      IDX_EVENT: rd_byte = event_input_control_r;
      IDX_TX_PULSE: rd_byte = ir_tx_pulse_length_r;
      IDX_RX_PULSE: rd_byte = {1'b0, ir_rx_pulse_length_r};
      default: rd_mapped = 1'b0;
    endcase
    if (ar_idx != IDX_BAUD) begin
      rd_word = {8'h00, rd_byte};
    end
  end

  // One read at a time; the answer is registered one cycle after the address.
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else if (rd_go) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {16'h0000, rd_word};
      s_axi_rresp <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // Interrupt lines are levels that follow enabled flags.
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      receive_complete_vector_r <= 1'b0;
      tx_buffer_empty_vector_r <= 1'b0;
      transmit_complete_vector_r <= 1'b0;
    end else begin
      receive_complete_vector_r <=
        (rx_unread_flag && interrupt_enable_control_r[CA_RX_IE]) ||
        (rx_start_flag_r && interrupt_enable_control_r[CA_RXS_IE]) ||
        (bad_sync_field_flag_r && interrupt_enable_control_r[CA_ABE_IE]);
      tx_buffer_empty_vector_r <=
        tx_buffer_empty_flag && interrupt_enable_control_r[CA_DRE_IE];
      transmit_complete_vector_r <=
        tx_done_flag_r && interrupt_enable_control_r[CA_TXC_IE];
    end
  end

endmodule : uib_uart_regs
`default_nettype wire

// ==== testbench/uib_uart_regs_sva.sv ====
`timescale 1ns/1ps
`default_nettype none
module uib_uart_regs_sva
  import uib_pkg::*;
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic s_axi_awvalid,
  input wire logic rx_pin,
  input wire logic ir_event_in,
  input wire logic rx_char_valid,
  input wire logic rx_start_seen,
  input wire logic sync_error_seen,
  input wire logic tx_frame_sent,
  input wire logic tx_buffer_full_r,
  input wire logic ir_rx_source_r,
  input wire logic [7:0] interrupt_enable_control_r,
  input wire logic [7:0] enable_and_rx_mode_control_r,
  input wire logic receive_complete_vector_r,
  input wire logic tx_buffer_empty_vector_r,
  input wire logic transmit_complete_vector_r
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (sys_rst);
  wire logic [7:0] ie = interrupt_enable_control_r;
  wire logic [7:0] en = enable_and_rx_mode_control_r;
  wire logic rcv = receive_complete_vector_r;
  wire logic transmit_complete_vector = transmit_complete_vector_r;
  logic [2:0] quiet_r;
  // Counts cycles since the last write request, so the level check skips flag clears.
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) quiet_r <= 3'h0;
    else if (s_axi_awvalid) quiet_r <= 3'h0;
    else if (quiet_r != 3'h7) quiet_r <= quiet_r + 3'h1;
  end
  property p_ir_src;
    !$past(sys_rst) && $past(rx_pin) == $past(ir_event_in) |-> ir_rx_source_r == $past(rx_pin);
  endproperty
  a_ir_src: assert property (p_ir_src) else $error("ir source wrong");
  property p_rx_char;
    rx_char_valid && en[CB_RX_EN] && ie[CA_RX_IE] |-> ##[1:4] rcv;
  endproperty
  a_rx_char: assert property (p_rx_char) else $error("no rx request");
  property p_rx_start;
    rx_start_seen && en[CB_START_DET_EN] && ie[CA_RXS_IE] |-> ##[1:3] rcv;
  endproperty
  a_rx_start: assert property (p_rx_start) else $error("no start request");
  property p_sync;
    sync_error_seen && ie[CA_ABE_IE] |-> ##[1:3] rcv;
  endproperty
  a_sync: assert property (p_sync) else $error("no sync request");
  property p_dre_on;
    (!tx_buffer_full_r && ie[CA_DRE_IE])[*4] |-> tx_buffer_empty_vector_r;
  endproperty
  a_dre_on: assert property (p_dre_on) else $error("no empty request");
  property p_dre_off;
    !$past(sys_rst) && !$past(ie[CA_DRE_IE]) |-> !tx_buffer_empty_vector_r;
  endproperty
  a_dre_off: assert property (p_dre_off) else $error("empty request masked");
  property p_txc_off;
    !$past(sys_rst) && !$past(ie[CA_TXC_IE]) |-> !transmit_complete_vector;
  endproperty
  a_txc_off: assert property (p_txc_off) else $error("done request masked");
  property p_txc_set;
    tx_frame_sent && !tx_buffer_full_r && ie[CA_TXC_IE] |-> ##[1:3] transmit_complete_vector;
  endproperty
  a_txc_set: assert property (p_txc_set) else $error("no done request");
  property p_txc_hold;
    transmit_complete_vector && quiet_r == 3'h7 |=> transmit_complete_vector;
  endproperty
  a_txc_hold: assert property (p_txc_hold) else $error("done request dropped");
  property p_rx_off;
    (!en[CB_RX_EN] && !ie[CA_RXS_IE] && !ie[CA_ABE_IE])[*5] |-> !rcv;
  endproperty
  a_rx_off: assert property (p_rx_off) else $error("flushed rx requests");
  property p_reset;
    $fell(sys_rst) |-> !rcv && !transmit_complete_vector;
  endproperty
  a_reset: assert property (p_reset) else $error("request after reset");
  c_rcv: cover property ($rose(rcv));
  c_txc: cover property ($rose(transmit_complete_vector));
  c_dre: cover property ($rose(tx_buffer_empty_vector_r));
endmodule : uib_uart_regs_sva
bind uib_uart_regs uib_uart_regs_sva uib_uart_regs_sva_i (.*);
`default_nettype wire

// ==== testbench/uib_serial_node.sv ====
`timescale 1ns/1ps
`default_nettype none
module uib_serial_node (
  input wire logic sys_clk,
  output logic rx_pin,
  output logic rx_start_seen,
  output logic rx_char_valid,
  output logic [8:0] rx_char_data,
  output logic rx_first_stop_bit,
  output logic rx_parity_bad
);
  initial begin
    rx_pin = 1'b1;
    rx_start_seen = 1'b0;
    rx_char_valid = 1'b0;
    rx_char_data = 9'h000;
    rx_first_stop_bit = 1'b1;
    rx_parity_bad = 1'b0;
  end
  // One character: start bit, then the finished character after gap cycles.
  task automatic send(input logic [8:0] d, input logic stp, input logic par, input int gap);
    @(posedge sys_clk);
    rx_pin <= 1'b0;
    rx_start_seen <= 1'b1;
    @(posedge sys_clk);
    rx_start_seen <= 1'b0;
    repeat (gap) @(posedge sys_clk);
    rx_pin <= 1'b1;
    rx_char_valid <= 1'b1;
    rx_char_data <= d;
    rx_first_stop_bit <= stp;
    rx_parity_bad <= par;
    @(posedge sys_clk);
    rx_char_valid <= 1'b0;
    rx_char_data <= ~d;
    rx_first_stop_bit <= ~stp;
    rx_parity_bad <= ~par;
  endtask : send
endmodule : uib_serial_node
`default_nettype wire

// ==== testbench/uib_uart_regs_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin fails++; \
  $display("mismatch %0t got %h exp %h", $time, a, b); end end
module uib_uart_regs_bench
  import uib_pkg::*;
;
  localparam logic [33:0] ALL = 34'h3FFFFFFFF;
  logic sys_clk, sys_rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [DATA_W-1:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic rx_pin, ir_event_in, rx_char_valid, rx_first_stop_bit, rx_parity_bad, rx_start_seen;
  logic [8:0] rx_char_data;
  logic sync_error_seen, break_seen, tx_buffer_taken, tx_frame_sent, ir_rx_source_r;
  logic tx_buffer_full_r;
  logic [7:0] tx_data_r, txd;
  logic receive_complete_vector_r, tx_buffer_empty_vector_r, transmit_complete_vector_r;
  logic [7:0] interrupt_enable_control_r, enable_and_rx_mode_control_r;
  logic [33:0] exp_q[$], msk_q[$], em, mm;
  logic [8:0] cd[4];
  int fails = 0, total_checks = 0, cycles = 0, seed = 64;
  uib_uart_regs uib_uart_regs_i (.*, .tx_data9_r(), .wait_break_r(),
    .frame_format_control_r(), .bit_rate_divisor_r(), .debug_run_control_r(),
    .ir_tx_pulse_length_r(), .ir_rx_pulse_length_r());
  uib_serial_node uib_serial_node_i (.*);
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  task automatic final_report();
    if (fails == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : final_report
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 5000) begin
      fails++;
      final_report();
    end
  end
  always @(posedge sys_clk) begin
    if (s_axi_rvalid && s_axi_rready) begin
      em = exp_q.pop_front();
      mm = msk_q.pop_front();
      `CHK({s_axi_rresp, s_axi_rdata} & mm, em & mm)
    end
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : cyc
  task automatic wr(input logic [3:0] i, input logic [31:0] d, input logic [1:0] e);
    @(posedge sys_clk);
    s_axi_awaddr <= {i, 2'b00};
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    `CHK(s_axi_bresp, e)
  endtask : wr
  task automatic rd(input logic [3:0] i, input logic [33:0] e, input logic [33:0] m);
    @(posedge sys_clk);
    exp_q.push_back(e);
    msk_q.push_back(m);
    s_axi_araddr <= {i, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
  endtask : rd
  function automatic logic [33:0] hi(input logic u, o, f, p, d8);
    return {RESP_OKAY, 24'h000000, u, o, 3'b000, f, p, d8};
  endfunction : hi
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 44'h0;
    s_axi_wstrb = 4'hF;
    {ir_event_in, sync_error_seen, break_seen, tx_buffer_taken, tx_frame_sent} = 5'h00;
    sys_rst = 1'b1;
    cyc(20);
    sys_rst <= 1'b0;
    rd(IDX_RXDATA_LOW, 34'h0, ALL);
    rd(IDX_RXDATA_HIGH, 34'h0, ALL);
    rd(4'h9, {RESP_SLVERR, 32'h0}, ALL);
    wr(4'h9, 32'hFF, RESP_SLVERR);
    wr(IDX_EVENT, 32'h1, RESP_OKAY);
    cyc(2);
    `CHK(ir_rx_source_r, 1'b0)
    wr(IDX_EVENT, 32'h0, RESP_OKAY);
    cyc(2);
    `CHK(ir_rx_source_r, 1'b1)
    wr(IDX_CTRL_IRQ, 32'h20, RESP_OKAY);
    cyc(4);
    `CHK(tx_buffer_empty_vector_r, 1'b1)
    txd = 8'($random(seed));
    wr(IDX_TXDATA_LOW, {24'h000000, txd}, RESP_OKAY);
    wr(IDX_TXDATA_LOW, {24'h000000, ~txd}, RESP_OKAY);
    rd(IDX_TXDATA_LOW, {RESP_OKAY, 24'h000000, txd}, ALL);
    `CHK(tx_buffer_empty_vector_r, 1'b0)
    `CHK(tx_buffer_full_r, 1'b1)
    `CHK(tx_data_r, txd)
    tx_buffer_taken <= 1'b1;
    cyc(1);
    tx_buffer_taken <= 1'b0;
    wr(IDX_CTRL_IRQ, 32'h0, RESP_OKAY);
    tx_frame_sent <= 1'b1;
    cyc(1);
    tx_frame_sent <= 1'b0;
    cyc(3);
    `CHK(transmit_complete_vector_r, 1'b0)
    rd(IDX_STATUS, {RESP_OKAY, 32'h60}, 34'h3000000E0);
    wr(IDX_CTRL_IRQ, 32'h40, RESP_OKAY);
    `CHK(interrupt_enable_control_r, 8'h40)
    cyc(20);
    `CHK(transmit_complete_vector_r, 1'b1)
    wr(IDX_STATUS, 32'h40, RESP_OKAY);
    cyc(3);
    `CHK(transmit_complete_vector_r, 1'b0)
    tx_frame_sent <= 1'b1;
    cyc(1);
    tx_frame_sent <= 1'b0;
    cyc(3);
    `CHK(transmit_complete_vector_r, 1'b1)
    wr(IDX_STATUS, 32'h40, RESP_OKAY);
    cyc(3);
    `CHK(transmit_complete_vector_r, 1'b0)
    wr(IDX_CTRL_FRAME, 32'h17, RESP_OKAY);
    wr(IDX_CTRL_ENABLE, 32'h90, RESP_OKAY);
    wr(IDX_CTRL_IRQ, 32'h14, RESP_OKAY);
    sync_error_seen <= 1'b1;
    cyc(1);
    sync_error_seen <= 1'b0;
    wr(IDX_STATUS, 32'h08, RESP_OKAY);
    for (int k = 0; k < 4; k++) begin
      cd[k] = 9'($random(seed));
      uib_serial_node_i.send(cd[k], k != 0, k == 1, k + 1);
    end
    cyc(2);
    `CHK(receive_complete_vector_r, 1'b1)
    wr(IDX_STATUS, 32'h10, RESP_OKAY);
    cyc(3);
    `CHK(receive_complete_vector_r, 1'b0)
    for (int k = 0; k < 3; k++) begin
      rd(IDX_RXDATA_HIGH, hi(1'b1, k == 2, k == 0, k == 1, cd[k][8]), ALL);
      rd(IDX_RXDATA_HIGH, hi(1'b1, k == 2, k == 0, k == 1, cd[k][8]), ALL);
      rd(IDX_RXDATA_LOW, {RESP_OKAY, 24'h000000, cd[k][7:0]}, ALL);
    end
    rd(IDX_RXDATA_HIGH, 34'h0, ALL);
    wr(IDX_CTRL_IRQ, 32'h80, RESP_OKAY);
    uib_serial_node_i.send(cd[3], 1'b1, 1'b0, 2);
    cyc(4);
    `CHK(receive_complete_vector_r, 1'b1)
    wr(IDX_CTRL_ENABLE, 32'h0, RESP_OKAY);
    cyc(3);
    `CHK(receive_complete_vector_r, 1'b0)
    rd(IDX_RXDATA_HIGH, 34'h0, ALL);
    wr(IDX_CTRL_FRAME, 32'h06, RESP_OKAY);
    wr(IDX_CTRL_ENABLE, 32'h80, RESP_OKAY);
    uib_serial_node_i.send(cd[0], 1'b1, 1'b1, 3);
    cyc(3);
    rd(IDX_RXDATA_LOW, {RESP_OKAY, 24'h000000, cd[0][7:0]}, ALL);
    rd(IDX_RXDATA_HIGH, hi(1'b1, 1'b0, 1'b0, 1'b0, cd[0][8]), ALL);
    rd(IDX_RXDATA_HIGH, 34'h0, ALL);
    cyc(4);
    final_report();
  end
endmodule : uib_uart_regs_bench
`default_nettype wire
